// ==== line_sampler.sv ====
`timescale 1ns/1ps
module line_sampler
  import tsense_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start,
  output logic      stop
);
  sampler_s smp_ff;
  sampler_s nxt_smp;

  // =======================================
  // two-flop sync plus one delay stage
  always_comb begin
    nxt_smp       = smp_ff;
    nxt_smp.scl_p = {smp_ff.scl_p[1:0], scl_in};
    nxt_smp.sda_p = {smp_ff.sda_p[1:0], sda_in};
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      smp_ff <= '1;
    end else begin
      smp_ff <= nxt_smp;
    end
  end

  // edges use stages 1 and 2 only, never the metastable stage 0
  assign scl      = smp_ff.scl_p[1];
  assign sda      = smp_ff.sda_p[1];
  assign scl_rise = smp_ff.scl_p[1] & ~smp_ff.scl_p[2];
  assign scl_fall = ~smp_ff.scl_p[1] & smp_ff.scl_p[2];
  assign start    = smp_ff.scl_p[1] & smp_ff.scl_p[2] & ~smp_ff.sda_p[1] & smp_ff.sda_p[2];
  assign stop     = smp_ff.scl_p[1] & smp_ff.scl_p[2] & smp_ff.sda_p[1] & ~smp_ff.sda_p[2];
endmodule

// ==== smbus_host.sv ====
`timescale 1ns/1ps
`include "tsense_cfg.svh"
module smbus_host
  import tsense_pkg::*;
#(
  parameter int QTR_CYC = `HOST_QTR_CYC
)
(
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  smbus_if.host           BUS,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic [7:0]      RDATA
);
  host_state_s h_ff;
  host_state_s nxt_h;
  logic        sda;
  logic        tick;
  logic        rxing;

  line_sampler u_sampler (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .scl_in   (BUS.scl),
    .sda_in   (BUS.sda),
    .scl      (),
    .sda      (sda),
    .scl_rise (),
    .scl_fall (),
    .start    (),
    .stop     ()
  );

  assign tick  = (h_ff.ph != H_IDLE) && (h_ff.div == 8'(QTR_CYC - 1));
  assign rxing = (h_ff.kind == `KIND_READ && h_ff.bnum == 2'h3) || (h_ff.kind == `KIND_RECV && h_ff.bnum == 2'h1);

  // =======================================
  // register port and bit engine
  always_comb begin
    nxt_h     = h_ff;
    nxt_h.rdq = 8'h00;
    if (RD) begin
      case (ADDR)
        `HREG_CTRL:   nxt_h.rdq = {6'h00, h_ff.kind};
        `HREG_CMD:    nxt_h.rdq = h_ff.cmd;
        `HREG_WDATA:  nxt_h.rdq = h_ff.wdata;
        `HREG_RESULT: nxt_h.rdq = h_ff.result;
        `HREG_STATUS: nxt_h.rdq = {6'h00, h_ff.nack, h_ff.busy};
        `HREG_SLAVE:  nxt_h.rdq = {1'b0, h_ff.slave};
        default:      nxt_h.rdq = 8'h00;
      endcase
    end
    if (WR) begin
      case (ADDR)
        `HREG_CMD:   nxt_h.cmd = WDATA;
        `HREG_WDATA: nxt_h.wdata = WDATA;
        `HREG_SLAVE: nxt_h.slave = WDATA[6:0];
        default: begin
          // a start while busy or with an unknown kind is dropped
          if (ADDR == `HREG_CTRL && !h_ff.busy && WDATA[1:0] != 2'h3) begin
            nxt_h.ph   = H_START;
            nxt_h.kind = WDATA[1:0];
            nxt_h.busy = 1'b1;
            nxt_h.nack = 1'b0;
            nxt_h.q    = 2'h0;
            nxt_h.div  = 8'h00;
            nxt_h.bnum = 2'h0;
            nxt_h.tx   = {h_ff.slave, WDATA[1:0] == `KIND_RECV};
          end
        end
      endcase
    end
    if (h_ff.ph != H_IDLE) begin
      nxt_h.div = tick ? 8'h00 : h_ff.div + 8'h01;
    end
    if (tick) begin
      nxt_h.q = h_ff.q + 2'h1;
      case (h_ff.ph)
        H_START: begin
          case (h_ff.q)
            2'h0: nxt_h.sda_oe = 1'b0;
            2'h1: nxt_h.scl_oe = 1'b0;
            2'h2: nxt_h.sda_oe = 1'b1;
            default: begin
              nxt_h.scl_oe = 1'b1;
              nxt_h.ph     = H_BIT;
              nxt_h.bitn   = 4'h0;
            end
          endcase
        end
        H_BIT: begin
          case (h_ff.q)
            2'h0: nxt_h.sda_oe = (h_ff.bitn != 4'h8) && !rxing && !h_ff.tx[7];
            2'h1: nxt_h.scl_oe = 1'b0;
            2'h2: begin
              if (h_ff.bitn != 4'h8) begin
                nxt_h.rx = {h_ff.rx[6:0], sda};
                nxt_h.tx = {h_ff.tx[6:0], 1'b0};
              end else if (!rxing) begin
                nxt_h.nack = sda;
              end
            end
            default: begin
              nxt_h.scl_oe = 1'b1;
              nxt_h.bitn   = h_ff.bitn + 4'h1;
              if (h_ff.bitn == 4'h8) begin
                nxt_h.bitn = 4'h0;
                nxt_h.bnum = h_ff.bnum + 2'h1;
                nxt_h.tx   = (h_ff.bnum == 2'h0) ? h_ff.cmd : h_ff.wdata;
                if (rxing) begin
                  nxt_h.result = h_ff.rx;
                  nxt_h.ph     = H_STOP;
                end else if (h_ff.nack || (h_ff.kind == `KIND_WRITE && h_ff.bnum == 2'h2)) begin
                  nxt_h.ph = H_STOP;
                end else if (h_ff.kind == `KIND_READ && h_ff.bnum == 2'h1) begin
                  nxt_h.ph = H_START;
                  nxt_h.tx = {h_ff.slave, 1'b1};
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (h_ff.q)
            2'h0: nxt_h.sda_oe = 1'b1;
            2'h1: nxt_h.scl_oe = 1'b0;
            2'h2: nxt_h.sda_oe = 1'b0;
            default: begin
              nxt_h.ph   = H_IDLE;
              nxt_h.busy = 1'b0;
            end
          endcase
        end
        default: nxt_h.ph = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      h_ff       <= '0;
      h_ff.slave <= `SLAVE_ADDR_DEF;
    end else begin
      h_ff <= nxt_h;
    end
  end

  assign BUS.m_scl_o  = 1'b0;
  assign BUS.m_scl_oe = h_ff.scl_oe;
  assign BUS.m_sda_o  = 1'b0;
  assign BUS.m_sda_oe = h_ff.sda_oe;
  assign RDATA        = h_ff.rdq;
endmodule

// ==== smbus_if.sv ====
`timescale 1ns/1ps
interface smbus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // open drain: any enabled low driver wins, else pulled high
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport sensor (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// ==== smbus_properties.sv ====
`timescale 1ns/1ps
`include "tsense_cfg.svh"
module smbus_properties #(
  parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEF
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ====================
  // frame tracking from raw wire levels
  logic       scl_q;
  logic       sda_q;
  logic       rdir;
  logic       acked;
  logic [3:0] bitn;
  logic [1:0] byten;
  logic [7:0] sh;
  logic       rise;
  logic       st;
  logic       sp;

  assign rise = scl & ~scl_q;
  assign st   = scl & scl_q & sda_q & ~sda;
  assign sp   = scl & scl_q & ~sda_q & sda;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitn  <= 4'h0;
      byten <= 2'h0;
      sh    <= 8'h00;
      rdir  <= 1'b0;
      acked <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (st || sp) begin
        bitn  <= 4'h0;
        byten <= 2'h0;
        rdir  <= 1'b0;
        acked <= 1'b0;
      end else if (rise) begin
        sh   <= {sh[6:0], sda};
        bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
        // saturate: later bytes all behave like byte 3
        if (bitn == 4'h9 && byten != 2'h3) begin
          byten <= byten + 2'h1;
        end
        if (bitn == 4'h8 && byten == 2'h0) begin
          rdir  <= sh[0];
          acked <= s_sda_oe;
        end
      end
    end
  end

  // ====================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  addr_ack_match_a: assert property (
    rise && bitn == 4'h8 && byten == 2'h0 |-> s_sda_oe == (sh[7:1] == SLAVE_ADDR)) else $error("address ack wrong");
  write_data_ack_a: assert property (
    rise && bitn == 4'h8 && byten != 2'h0 && acked && !rdir |-> s_sda_oe) else $error("write byte not acked");
  read_ninth_free_a: assert property (
    rise && bitn == 4'h8 && byten != 2'h0 && rdir |-> !s_sda_oe) else $error("sensor holds sda at host nack");
  host_ninth_release_a: assert property (
    rise && bitn == 4'h8 |-> !m_sda_oe) else $error("host holds sda on ninth clock");
  addr_listen_a: assert property (
    byten == 2'h0 && bitn < 4'h8 |-> !s_sda_oe) else $error("sensor drives before address ack");
  unmatched_quiet_a: assert property (
    byten != 2'h0 && !acked |-> !s_sda_oe) else $error("unaddressed sensor drives sda");
  sda_steady_high_a: assert property (
    scl && scl_q |-> $stable(s_sda_oe)) else $error("sensor moves sda while scl high");
  bus_free_stop_a: assert property (
    sp |-> (scl && sda) [*8]) else $error("lines not idle after stop");
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
`include "tsense_cfg.svh"
module tb;
  logic       clk;
  logic       reset_n;
  logic       wr;
  logic       rd;
  logic       conv_done;
  logic       conv_enable;
  logic       standby;
  logic       data_ready;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] conv_data;
  logic [7:0] rdata;
  logic [7:0] temp_value;
  int         n_fail;
  int         samples_checked;
  int         cycles;

  smbus_if bus();
  smbus_host #(.QTR_CYC(6)) u_smbus_host (.CLK(clk), .RESET_N(reset_n), .BUS(bus), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  tsense_slave u_tsense_slave (.CLK(clk), .RESET_N(reset_n), .BUS(bus), .CONV_DONE(conv_done),
    .CONV_DATA(conv_data), .CONV_ENABLE(conv_enable), .TEMP_VALUE(temp_value), .STANDBY(standby),
    .DATA_READY(data_ready));
  smbus_properties u_smbus_properties (.CLK(clk), .RESET_N(reset_n), .m_sda_oe(bus.m_sda_oe),
    .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

  // ====================
  // helpers
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // one frame; the slave keeps no wait states, so busy is polled
  task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] r, output logic [7:0] nk);
    logic [7:0] st;
    int         i;
    reg_wr(`HREG_CMD, c);
    reg_wr(`HREG_WDATA, d);
    reg_wr(`HREG_CTRL, {6'h0, k});
    st = 8'h01;
    i = 0;
    while (st[0] !== 1'b0 && i < 3000) begin
      reg_rd(`HREG_STATUS, st);
      i++;
    end
    // a poll limit that runs out is a hung frame, counted as a mismatch
    chk({7'h0, st[0]}, 8'h00);
    nk = {7'h0, st[1]};
    reg_rd(`HREG_RESULT, r);
  endtask

  task automatic pulse(input logic [7:0] d);
    @(posedge clk);
    conv_data <= d;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // ====================
  // scenarios
  task automatic t_reset;
    logic [7:0] r;
    logic [7:0] nk;
    chk({6'h0, bus.scl, bus.sda}, 8'h03);
    reg_rd(`HREG_SLAVE, r);
    chk(r, {1'b0, `SLAVE_ADDR_DEF});
    reg_rd(3'h7, r);
    chk(r, 8'h00);
    chk({6'h0, standby, data_ready}, 8'h00);
    xfer(`KIND_READ, `SETUP_ACCESS_CMD, 8'h00, r, nk);
    chk(r, `SETUP_RESET);
    chk(nk, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_convert;
    logic [7:0] r;
    logic [7:0] nk;
    pulse(8'hE7);
    chk(temp_value, 8'hE7);
    chk({7'h0, data_ready}, 8'h01);
    xfer(`KIND_READ, `READ_THERMAL_CMD, 8'h00, r, nk);
    chk(r, 8'hE7);
    xfer(`KIND_READ, `SETUP_ACCESS_CMD, 8'h00, r, nk);
    chk(r, 8'h40);
    // receive-byte must follow the setup command, not the temperature one
    xfer(`KIND_RECV, `READ_THERMAL_CMD, 8'h00, r, nk);
    chk(r, 8'h40);
    $display("test convert done");
  endtask

  task automatic t_standby;
    logic [7:0] r;
    logic [7:0] nk;
    xfer(`KIND_WRITE, `SETUP_ACCESS_CMD, 8'hFF, r, nk);
    chk(nk, 8'h00);
    chk({7'h0, standby}, 8'h01);
    chk({6'h0, standby, data_ready}, 8'h02);
    chk({7'h0, conv_enable}, 8'h00);
    xfer(`KIND_READ, `SETUP_ACCESS_CMD, 8'h00, r, nk);
    chk(r, 8'h80);
    pulse(8'h19);
    chk(temp_value, 8'hE7);
    xfer(`KIND_READ, `READ_THERMAL_CMD, 8'h00, r, nk);
    chk(r, 8'hE7);
    xfer(`KIND_WRITE, `SETUP_ACCESS_CMD, 8'h00, r, nk);
    chk({7'h0, standby}, 8'h00);
    chk({7'h0, conv_enable}, 8'h01);
    pulse(8'h19);
    chk(temp_value, 8'h19);
    // 19h reversed would read 98h, so bit order shows
    xfer(`KIND_READ, `READ_THERMAL_CMD, 8'h00, r, nk);
    chk(r, 8'h19);
    xfer(`KIND_READ, `SETUP_ACCESS_CMD, 8'h00, r, nk);
    chk(r, 8'h40);
    // the read-byte's write phase must have left command 01h behind
    xfer(`KIND_RECV, `READ_THERMAL_CMD, 8'h00, r, nk);
    chk(r, 8'h40);
    $display("test standby done");
  endtask

  task automatic t_ignored;
    logic [7:0] r;
    logic [7:0] nk;
    xfer(`KIND_WRITE, `READ_THERMAL_CMD, 8'h55, r, nk);
    chk(nk, 8'h00);
    xfer(`KIND_READ, `READ_THERMAL_CMD, 8'h00, r, nk);
    chk(r, 8'h19);
    xfer(`KIND_WRITE, 8'h07, 8'hAA, r, nk);
    chk(nk, 8'h00);
    xfer(`KIND_READ, 8'h07, 8'h00, r, nk);
    chk(r, 8'h00);
    $display("test ignored done");
  endtask

  task automatic t_wrong_addr;
    logic [7:0] r;
    logic [7:0] nk;
    reg_wr(`HREG_SLAVE, 8'h4C);
    xfer(`KIND_WRITE, `SETUP_ACCESS_CMD, 8'h80, r, nk);
    chk(nk, 8'h01);
    chk({7'h0, standby}, 8'h00);
    reg_wr(`HREG_SLAVE, {1'b0, `SLAVE_ADDR_DEF});
    // slave must still hold command 07h, so zero and not the setup value
    xfer(`KIND_RECV, `SETUP_ACCESS_CMD, 8'h00, r, nk);
    chk(r, 8'h00);
    chk(nk, 8'h00);
    $display("test wrong address done");
  endtask

  // second reset with ready set, temperature 19h and command 07h held
  task automatic t_mid_reset;
    logic [7:0] r;
    logic [7:0] nk;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({6'h0, standby, data_ready}, 8'h00);
    chk({7'h0, conv_enable}, 8'h01);
    chk(temp_value, `TEMP_RESET);
    pulse(8'h7F);
    // command must be back at 00h, else the unknown code 07h would read zero
    xfer(`KIND_RECV, `SETUP_ACCESS_CMD, 8'h00, r, nk);
    chk(r, 8'h7F);
    $display("test mid reset done");
  endtask

  // ====================
  // clock, timeout, main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    conv_done = 1'b0;
    conv_data = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // sampler flops need a few edges before the line is watched
    repeat (4) @(posedge clk);
    t_reset();
    t_convert();
    t_standby();
    t_ignored();
    t_wrong_addr();
    t_mid_reset();
    end_sim();
  end
endmodule

// ==== tsense_cfg.svh ====
`ifndef TSENSE_CFG_SVH
`define TSENSE_CFG_SVH

// =======================================
// sensor registers and commands
`define READ_THERMAL_CMD 8'h00
`define SETUP_ACCESS_CMD 8'h01
`define STANDBY_BIT      7
`define READY_BIT        6
`define SETUP_RESET      8'h00
`define TEMP_RESET       8'h00
`define SLAVE_ADDR_DEF   7'h4D

// =======================================
// host registers and timing
`define HREG_CTRL        3'h0
`define HREG_CMD         3'h1
`define HREG_WDATA       3'h2
`define HREG_RESULT      3'h3
`define HREG_STATUS      3'h4
`define HREG_SLAVE       3'h5
`define KIND_WRITE       2'h0
`define KIND_READ        2'h1
`define KIND_RECV        2'h2
`define CLK_NS           10
`define HOST_QTR_NS      80
`define HOST_QTR_CYC     (`HOST_QTR_NS / `CLK_NS)
`endif

// ==== tsense_pkg.sv ====
package tsense_pkg;
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK} slave_phase_e;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_phase_e;

  typedef struct packed {
    logic [2:0] scl_p;
    logic [2:0] sda_p;
  } sampler_s;

  typedef struct packed {
    slave_phase_e ph;
    logic [3:0]   cnt;
    logic [1:0]   idx;
    logic         rd;
    logic         nack;
    logic [7:0]   shift;
    logic [7:0]   cmd;
    logic [7:0]   tx;
    logic         sda_oe;
    logic         standby_select;
    logic         ready;
    logic [7:0]   temperature_reading;
    logic         conv_en;
  } slave_state_s;

  typedef struct packed {
    host_phase_e ph;
    logic [1:0]  kind;
    logic [1:0]  q;
    logic [7:0]  div;
    logic [3:0]  bitn;
    logic [1:0]  bnum;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [7:0]  cmd;
    logic [7:0]  wdata;
    logic [7:0]  result;
    logic [6:0]  slave;
    logic        nack;
    logic        busy;
    logic        scl_oe;
    logic        sda_oe;
    logic [7:0]  rdq;
  } host_state_s;
endpackage

// ==== tsense_slave.sv ====
`timescale 1ns/1ps
`include "tsense_cfg.svh"
module tsense_slave
  import tsense_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEF
)
(
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  smbus_if.sensor         BUS,
  input  wire logic       CONV_DONE,
  input  wire logic [7:0] CONV_DATA,
  output logic            CONV_ENABLE,
  output logic [7:0]      TEMP_VALUE,
  output logic            STANDBY,
  output logic            DATA_READY
);
  slave_state_s st_ff;
  slave_state_s nxt_st;
  logic         scl;
  logic         sda;
  logic         scl_rise;
  logic         scl_fall;
  logic         ln_start;
  logic         ln_stop;
  logic [7:0]   read_val;

  // =======================================
  // line sampling
  line_sampler u_sampler (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .scl_in   (BUS.scl),
    .sda_in   (BUS.sda),
    .scl      (scl),
    .sda      (sda),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start    (ln_start),
    .stop     (ln_stop)
  );

  // =======================================
  // register read mux
  always_comb begin
    case (st_ff.cmd)
      `READ_THERMAL_CMD: begin
        read_val = st_ff.temperature_reading;
      end
      `SETUP_ACCESS_CMD: begin
        read_val = {st_ff.standby_select, st_ff.ready, 6'h00};
      end
      default: begin
        read_val = 8'h00;
      end
    endcase
  end

  // =======================================
  // next state
  always_comb begin
    nxt_st = st_ff;

    // converter side
    nxt_st.conv_en = ~st_ff.standby_select;
    if (CONV_DONE && !st_ff.standby_select) begin
      // value and flag move together, so a reader never sees ready with stale data
      nxt_st.temperature_reading = CONV_DATA;
      nxt_st.ready               = 1'b1;
    end

    // serial side
    if (ln_stop) begin
      nxt_st.ph     = S_IDLE;
      nxt_st.sda_oe = 1'b0;
    end else if (ln_start) begin
      nxt_st.ph     = S_RX;
      nxt_st.cnt    = 4'h0;
      nxt_st.idx    = 2'h0;
      nxt_st.rd     = 1'b0;
      nxt_st.sda_oe = 1'b0;
    end else begin
      case (st_ff.ph)
        S_IDLE: begin
          nxt_st.sda_oe = 1'b0;
        end

        S_RX: begin
          if (scl_rise && st_ff.cnt != 4'h8) begin
            nxt_st.shift = {st_ff.shift[6:0], sda};
            nxt_st.cnt   = st_ff.cnt + 4'h1;
          end else if (scl_fall && st_ff.cnt == 4'h8) begin
            nxt_st.ph     = S_ACK;
            nxt_st.sda_oe = 1'b1;
            case (st_ff.idx)
              2'h0: begin
                if (st_ff.shift[7:1] == SLAVE_ADDR) begin
                  nxt_st.rd = st_ff.shift[0];
                end else begin
                  nxt_st.ph     = S_IDLE;
                  nxt_st.sda_oe = 1'b0;
                end
              end
              2'h1: begin
                nxt_st.cmd = st_ff.shift;
              end
              default: begin
                // temperature and unknown codes are acked but change nothing
                if (st_ff.cmd == `SETUP_ACCESS_CMD) begin
                  nxt_st.standby_select = st_ff.shift[`STANDBY_BIT];
                end
              end
            endcase
          end
        end

        S_ACK: begin
          if (scl_fall) begin
            nxt_st.cnt = 4'h0;
            if (st_ff.rd) begin
              nxt_st.ph     = S_TX;
              nxt_st.tx     = read_val;
              nxt_st.sda_oe = ~read_val[7];
            end else begin
              nxt_st.ph     = S_RX;
              nxt_st.sda_oe = 1'b0;
              // further data bytes keep landing on the same register
              if (st_ff.idx != 2'h2) begin
                nxt_st.idx = st_ff.idx + 2'h1;
              end
            end
          end
        end

        S_TX: begin
          if (scl_fall) begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
            nxt_st.tx  = {st_ff.tx[6:0], 1'b0};
            if (st_ff.cnt == 4'h7) begin
              nxt_st.ph     = S_TXACK;
              nxt_st.sda_oe = 1'b0;
            end else begin
              nxt_st.sda_oe = ~st_ff.tx[6];
            end
          end
        end

        S_TXACK: begin
          if (scl_rise) begin
            nxt_st.nack = sda;
          end else if (scl_fall) begin
            if (st_ff.nack) begin
              nxt_st.ph = S_IDLE;
            end else begin
              nxt_st.ph     = S_TX;
              nxt_st.cnt    = 4'h0;
              nxt_st.tx     = read_val;
              nxt_st.sda_oe = ~read_val[7];
            end
          end
        end

        default: begin
          nxt_st.ph     = S_IDLE;
          nxt_st.sda_oe = 1'b0;
        end
      endcase
    end

    // selecting standby clears ready and holds it clear
    if (nxt_st.standby_select) begin
      nxt_st.ready = 1'b0;
    end
  end

  // =======================================
  // state register
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =======================================
  // outputs
  // open drain: only ever pulls low, level 0 is fixed
  assign BUS.s_sda_o  = 1'b0;
  assign BUS.s_sda_oe = st_ff.sda_oe;
  assign CONV_ENABLE  = st_ff.conv_en;
  assign TEMP_VALUE   = st_ff.temperature_reading;
  assign STANDBY      = st_ff.standby_select;
  assign DATA_READY   = st_ff.ready;
endmodule
